/* hdl/gi2c_controller.sv */
`timescale 1ns/10ps
module gi2c_controller #(
  parameter int POST_WR_CYCLES = gi2c_pkg::POST_WR_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  // Command
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_read_i,
  input  wire logic       cmd_quick_i,
  input  wire logic [7:0] cmd_addr_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            cmd_ready_o,
  // Response
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            rsp_nack_o,
  // Bus
  gi2c_if.host            bus
);
  typedef struct packed {
    logic                scl_m;
    logic                scl_s;
    logic                sda_m;
    logic                sda_s;
    gi2c_pkg::gi2c_hst_t st;
    logic [1:0]          step;
    logic [3:0]          bitc;
    logic [7:0]          sh;
    logic [9:0]          cnt;
    logic [24:0]         wt;
    logic                rd;
    logic                quick;
    logic [7:0]          addr;
    logic [7:0]          data;
    logic                scl_oe;
    logic                sda_oe;
    logic                cmd_ready;
    logic                rsp_valid;
    logic [7:0]          rsp_data;
    logic                rsp_nack;
  } gi2c_ctl_st_t;

  gi2c_ctl_st_t r;
  gi2c_ctl_st_t n;
  logic         half;
  logic         rd_step;

  // Bytes of a packet: address, command, data or restart address, read
  function automatic logic [7:0] byte_of(input logic [1:0] s, input gi2c_ctl_st_t q);
    case (s)
      2'h0:    byte_of = gi2c_pkg::WR_FIRST;
      2'h1:    byte_of = q.addr;
      2'h2:    byte_of = q.rd ? gi2c_pkg::RD_FIRST : q.data;
      default: byte_of = 8'hff;
    endcase
  endfunction : byte_of

  assign half    = r.cnt == 10'(gi2c_pkg::HALF_CYC - 1);
  assign rd_step = r.rd && r.step == 2'h3;

  always_comb begin
    n           = r;
    n.rsp_valid = 1'b0;
    n.scl_m     = bus.scl;
    n.scl_s     = r.scl_m;
    n.sda_m     = bus.sda;
    n.sda_s     = r.sda_m;
    if (r.wt != '0) begin
      n.wt = r.wt - 1'b1;
    end
    case (r.st)
      gi2c_pkg::HS_IDLE: begin
        // Every command waits out the settle time of a previous write
        n.cmd_ready = !(cmd_valid_i && r.cmd_ready) && r.wt == '0;
        if (cmd_valid_i && r.cmd_ready) begin
          n.rd       = cmd_read_i;
          n.quick    = cmd_read_i && cmd_quick_i;
          n.addr     = cmd_addr_i;
          n.data     = cmd_data_i;
          n.step     = (cmd_read_i && cmd_quick_i) ? 2'h2 : 2'h0;
          n.rsp_nack = 1'b0;
          n.cnt      = '0;
          n.sda_oe   = 1'b1;
          n.st       = gi2c_pkg::HS_START;
        end
      end
      gi2c_pkg::HS_START: begin
        if (r.scl_s) begin
          n.cnt = r.cnt + 1'b1;
          if (half) begin
            n.scl_oe = 1'b1;
            n.cnt    = '0;
            n.bitc   = '0;
            n.sh     = byte_of(r.step, r);
            n.st     = gi2c_pkg::HS_LOW;
          end
        end
      end
      gi2c_pkg::HS_LOW: begin
        n.sda_oe = r.bitc != 4'h8 && !rd_step && !r.sh[7];
        n.cnt    = r.cnt + 1'b1;
        if (half) begin
          n.scl_oe = 1'b0;
          n.cnt    = '0;
          n.st     = gi2c_pkg::HS_HIGH;
        end
      end
      gi2c_pkg::HS_HIGH: begin
        // Count only once SCL is really high, so any stretch is honoured
        if (r.scl_s) begin
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == '0 && r.bitc != 4'h8) begin
            n.sh = {r.sh[6:0], r.sda_s};
          end else if (r.cnt == '0 && !rd_step) begin
            n.rsp_nack = r.sda_s;
          end
          if (half) begin
            n.scl_oe = 1'b1;
            n.cnt    = '0;
            if (r.bitc != 4'h8) begin
              n.bitc = r.bitc + 1'b1;
              n.st   = gi2c_pkg::HS_LOW;
            end else if (r.rsp_nack || r.step == (r.rd ? 2'h3 : 2'h2)) begin
              n.st = gi2c_pkg::HS_STOP1;
            end else begin
              n.step = r.step + 1'b1;
              n.bitc = '0;
              n.sh   = byte_of(r.step + 1'b1, r);
              n.st   = (r.rd && r.step == 2'h1) ? gi2c_pkg::HS_RS1 : gi2c_pkg::HS_LOW;
            end
          end
        end
      end
      gi2c_pkg::HS_RS1: begin
        n.sda_oe = 1'b0;
        n.cnt    = r.cnt + 1'b1;
        if (half) begin
          n.scl_oe = 1'b0;
          n.cnt    = '0;
          n.st     = gi2c_pkg::HS_RS2;
        end
      end
      gi2c_pkg::HS_RS2: begin
        if (r.scl_s) begin
          n.cnt = r.cnt + 1'b1;
          if (half) begin
            n.sda_oe = 1'b1;
            n.cnt    = '0;
            n.st     = gi2c_pkg::HS_START;
          end
        end
      end
      gi2c_pkg::HS_STOP1: begin
        n.sda_oe = 1'b1;
        n.cnt    = r.cnt + 1'b1;
        if (half) begin
          n.scl_oe = 1'b0;
          n.cnt    = '0;
          n.st     = gi2c_pkg::HS_STOP2;
        end
      end
      gi2c_pkg::HS_STOP2: begin
        if (r.scl_s) begin
          n.cnt = r.cnt + 1'b1;
          if (half) begin
            n.sda_oe    = 1'b0;
            n.cnt       = '0;
            n.rsp_valid = 1'b1;
            n.rsp_data  = r.rd ? r.sh : 8'h00;
            n.st        = gi2c_pkg::HS_GAP;
            if (!r.rd && !r.rsp_nack) begin
              n.wt = 25'(POST_WR_CYCLES);
            end
          end
        end
      end
      gi2c_pkg::HS_GAP: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == 10'(gi2c_pkg::BUF_CYC - 1)) begin
          n.cnt = '0;
          n.st  = gi2c_pkg::HS_IDLE;
        end
      end
      default: begin
        n.st = gi2c_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r       <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
    end else if (en_i) begin
      r <= n;
    end
  end

  assign cmd_ready_o     = r.cmd_ready;
  assign rsp_valid_o     = r.rsp_valid;
  assign rsp_data_o      = r.rsp_data;
  assign rsp_nack_o      = r.rsp_nack;
  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_oe = r.sda_oe;
endmodule : gi2c_controller

/* hdl/gi2c_fifo.sv */
`timescale 1ns/10ps
module gi2c_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } gi2c_fifo_st_t;
  gi2c_fifo_st_t    r;
  gi2c_fifo_st_t    n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Flags come from the count only
  assign in_ready_o  = r.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = r.cnt != '0;
  assign out_data_o  = mem[r.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    n = r;
    if (push) begin
      n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (en_i) begin
      r <= n;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (en_i && push) begin
      mem[r.wp] <= in_data_i;
    end
  end
endmodule : gi2c_fifo

/* hdl/gi2c_target.sv */
`timescale 1ns/10ps
module gi2c_target #(
  parameter int TIMEOUT_CYCLES = gi2c_pkg::TIMEOUT_CYC,
  parameter int WAKE_CYCLES    = gi2c_pkg::WAKE_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                en_i,
  // Gauge state
  input  wire gi2c_pkg::gi2c_pwr_t pwr_state_i,
  input  wire logic                flash_busy_i,
  // Gauge updates of command locations
  input  wire logic                upd_valid_i,
  input  wire logic [6:0]          upd_addr_i,
  input  wire logic [7:0]          upd_data_i,
  // Bytes written by the master
  output logic                     wr_valid_o,
  output logic [7:0]               wr_addr_o,
  output logic [7:0]               wr_data_o,
  input  wire logic                wr_ready_i,
  // Status
  output logic                     bus_sleep_o,
  // Bus
  gi2c_if.device                   bus
);
  typedef struct packed {
    logic               scl_m;
    logic               scl_s;
    logic               scl_p;
    logic               sda_m;
    logic               sda_s;
    logic               sda_p;
    gi2c_pkg::gi2c_ph_t ph;
    logic [3:0]         bitc;
    logic [7:0]         sh;
    logic [7:0]         ptr;
    logic               addr_byte;
    logic               cmd_byte;
    logic               rw;
    logic               nack;
    logic               own;
    logic               seen;
    logic               scl_oe;
    logic               sda_oe;
    logic [15:0]        wake;
    logic [24:0]        to_cnt;
    logic               sleep;
    logic               push;
    logic [15:0]        push_data;
  } gi2c_tgt_st_t;

  gi2c_tgt_st_t r;
  gi2c_tgt_st_t n;
  logic [7:0]   mem [128];
  logic         fifo_ready;
  logic         rise;
  logic         fall;
  logic         start;
  logic         stop;
  logic         hold;
  logic [15:0]  fifo_out;

  // Byte returned for a location; nothing lives above the top command
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    rd_byte = (a > gi2c_pkg::CMD_TOP) ? 8'h00 : mem[a[6:0]];
  endfunction : rd_byte

  // Only the control locations accept master data
  function automatic logic writable(input logic [7:0] a);
    writable = a <= gi2c_pkg::CTRL_LAST;
  endfunction : writable

  // Edges seen on synchronised lines only
  assign rise  = r.scl_s && !r.scl_p;
  assign fall  = !r.scl_s && r.scl_p;
  assign start = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
  assign stop  = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;

  // Stretch: wake-up, flash busy in own packet, or full write buffer
  assign hold = (r.wake != '0)
    || (r.own && flash_busy_i && r.bitc <= 4'h1
        && (r.ph == gi2c_pkg::PH_RX || r.ph == gi2c_pkg::PH_TX))
    || (r.ph == gi2c_pkg::PH_RX && r.bitc == 4'h8 && !r.addr_byte
        && !r.cmd_byte && writable(r.ptr) && !fifo_ready);

  always_comb begin
    n       = r;
    n.push  = 1'b0;
    n.scl_m = bus.scl;
    n.scl_s = r.scl_m;
    n.scl_p = r.scl_s;
    n.sda_m = bus.sda;
    n.sda_s = r.sda_m;
    n.sda_p = r.sda_s;
    if (r.wake != '0) begin
      n.wake = r.wake - 1'b1;
    end
    case (r.ph)
      gi2c_pkg::PH_IDLE: begin
        n.ph = gi2c_pkg::PH_IDLE;
      end
      gi2c_pkg::PH_RX: begin
        if (rise && r.bitc < 4'h8) begin
          n.sh   = {r.sh[6:0], r.sda_s};
          n.bitc = r.bitc + 1'b1;
        end else if (r.bitc == 4'h8 && !r.scl_s) begin
          n.seen = 1'b0;
          if (r.addr_byte) begin
            if (r.sh[7:1] != gi2c_pkg::TARGET_ADDR) begin
              n.ph = gi2c_pkg::PH_IDLE;
            end else begin
              n.own  = 1'b1;
              n.rw   = r.sh[0];
              n.nack = 1'b0;
              n.ph   = gi2c_pkg::PH_ACK;
            end
          end else if (r.cmd_byte) begin
            n.ptr  = r.sh;
            n.nack = r.sh > gi2c_pkg::CMD_TOP;
            n.ph   = gi2c_pkg::PH_ACK;
          end else if (!writable(r.ptr)) begin
            n.nack = 1'b1;
            n.ph   = gi2c_pkg::PH_ACK;
          end else if (fifo_ready) begin
            n.push      = 1'b1;
            n.push_data = {r.ptr, r.sh};
            n.nack      = 1'b0;
            n.ph        = gi2c_pkg::PH_ACK;
          end
        end
      end
      gi2c_pkg::PH_ACK: begin
        if (rise) begin
          n.seen = 1'b1;
        end else if (r.seen && !r.scl_s) begin
          n.seen      = 1'b0;
          n.bitc      = '0;
          n.addr_byte = 1'b0;
          n.cmd_byte  = r.addr_byte && !r.rw;
          if (r.nack) begin
            n.ph = gi2c_pkg::PH_IDLE;
          end else if (r.addr_byte && r.rw) begin
            n.ph = gi2c_pkg::PH_TX;
            n.sh = rd_byte(r.ptr);
          end else begin
            if (!r.addr_byte && !r.cmd_byte) begin
              n.ptr = r.ptr + 1'b1;
            end
            n.ph = gi2c_pkg::PH_RX;
          end
        end
      end
      gi2c_pkg::PH_TX: begin
        if (fall) begin
          n.sh   = {r.sh[6:0], 1'b1};
          n.bitc = r.bitc + 1'b1;
          if (r.bitc == 4'h7) begin
            n.ph   = gi2c_pkg::PH_MACK;
            n.bitc = '0;
            n.seen = 1'b0;
          end
        end
      end
      gi2c_pkg::PH_MACK: begin
        if (rise) begin
          n.seen = 1'b1;
          n.nack = r.sda_s;
        end else if (r.seen && !r.scl_s) begin
          n.seen = 1'b0;
          if (r.nack) begin
            n.ph = gi2c_pkg::PH_IDLE;
          end else begin
            n.ptr = r.ptr + 1'b1;
            n.sh  = rd_byte(r.ptr + 1'b1);
            n.ph  = gi2c_pkg::PH_TX;
          end
        end
      end
      default: begin
        n.ph = gi2c_pkg::PH_IDLE;
      end
    endcase
    // Start and stop win over any phase
    if (start) begin
      n.ph        = gi2c_pkg::PH_RX;
      n.bitc      = '0;
      n.addr_byte = 1'b1;
      n.cmd_byte  = 1'b0;
      n.own       = 1'b0;
      n.seen      = 1'b0;
      if (pwr_state_i == gi2c_pkg::PWR_SLEEP || pwr_state_i == gi2c_pkg::PWR_HIBERNATE) begin
        n.wake = 16'(WAKE_CYCLES);
      end
    end else if (stop) begin
      n.ph  = gi2c_pkg::PH_IDLE;
      n.own = 1'b0;
    end
    // Grab SCL only while it is already low; after a stalled byte keep it one
    // more cycle so the ACK level settles before the clock is let go
    n.scl_oe = (hold && (!r.scl_s || r.scl_oe))
      || (r.scl_oe && r.ph == gi2c_pkg::PH_RX && n.ph == gi2c_pkg::PH_ACK);
    n.sda_oe = (n.ph == gi2c_pkg::PH_ACK && !n.nack) || (n.ph == gi2c_pkg::PH_TX && !n.sh[7]);
    // Bus-low watchdog; counts our own stretch too so it cannot hang
    if (!r.scl_s || !r.sda_s) begin
      if (r.to_cnt != 25'(TIMEOUT_CYCLES + gi2c_pkg::SETTLE_CYC)) begin
        n.to_cnt = r.to_cnt + 1'b1;
      end
    end else begin
      n.to_cnt = '0;
      n.sleep  = 1'b0;
    end
    if (r.to_cnt >= 25'(TIMEOUT_CYCLES - 1)) begin
      n.ph     = gi2c_pkg::PH_IDLE;
      n.own    = 1'b0;
      n.wake   = '0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end
    if (r.to_cnt == 25'(TIMEOUT_CYCLES + gi2c_pkg::SETTLE_CYC) && (!r.scl_s || !r.sda_s)) begin
      n.sleep = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r       <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_p <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_p <= 1'b1;
    end else if (en_i) begin
      r <= n;
    end
  end

  // Command locations; gauge updates and accepted master writes
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (upd_valid_i) begin
        mem[upd_addr_i] <= upd_data_i;
      end
      if (r.push) begin
        mem[r.push_data[14:8]] <= r.push_data[7:0];
      end
    end
  end

  // Write buffer stalls the bus through the clock stretch
  gi2c_fifo #(.WIDTH(16), .DEPTH(gi2c_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .en_i        (en_i),
    .in_valid_i  (r.push),
    .in_data_i   (r.push_data),
    .in_ready_o  (fifo_ready),
    .out_valid_o (wr_valid_o),
    .out_data_o  (fifo_out),
    .out_ready_i (wr_ready_i)
  );

  assign wr_addr_o      = fifo_out[15:8];
  assign wr_data_o      = fifo_out[7:0];
  assign bus_sleep_o    = r.sleep;
  assign bus.dev_scl_o  = 1'b0;
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_scl_oe = r.scl_oe;
  assign bus.dev_sda_oe = r.sda_oe;
endmodule : gi2c_target

/* inc/gi2c_if.sv */
`timescale 1ns/10ps
interface gi2c_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND of both open-drain ends with pull-up
  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
  modport device (input scl, sda, output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe);
  modport host (input scl, sda, output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : gi2c_if

/* inc/gi2c_pkg.sv */
package gi2c_pkg;
  // Addressing
  localparam logic [6:0] TARGET_ADDR = 7'h55;
  localparam logic [7:0] WR_FIRST    = 8'haa;
  localparam logic [7:0] RD_FIRST    = 8'hab;
  localparam logic [7:0] CMD_TOP     = 8'h6b;
  localparam logic [7:0] CTRL_LAST   = 8'h01;
  // Timing, clock is 100 ns
  localparam int CLK_NS        = 100;
  localparam int TIMEOUT_MS    = 2000;
  localparam int TIMEOUT_CYC   = TIMEOUT_MS * 1000000 / CLK_NS;
  localparam int SETTLE_CYC    = 4;
  localparam int WAKE_US       = 4000;
  localparam int WAKE_CYC      = WAKE_US * 1000 / CLK_NS;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int HALF_CYC      = (SCL_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int BUF_US        = 66;
  localparam int BUF_CYC       = (BUF_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int POST_WR_MS    = 2000;
  localparam int POST_WR_CYC   = POST_WR_MS * 1000000 / CLK_NS;
  localparam int FIFO_DEPTH    = 4;
  // Power states of the gauge
  typedef enum logic [2:0] {
    PWR_BATTERY_DETECT_STATE, PWR_NORMAL, PWR_DEEP_SNOOZE, PWR_SLEEP, PWR_HIBERNATE
  } gi2c_pwr_t;
  // Target phases
  typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_MACK} gi2c_ph_t;
  // Controller states
  typedef enum logic [3:0] {
    HS_IDLE, HS_START, HS_LOW, HS_HIGH, HS_RS1, HS_RS2, HS_STOP1, HS_STOP2, HS_GAP
  } gi2c_hst_t;
endpackage : gi2c_pkg

/* sim/gauge_i2c_target_port_tb_top.sv */
`timescale 1ns/10ps
module gauge_i2c_target_port_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic c_en = 1'b1, vld = 1'b0, rd = 1'b0, qk = 1'b0, fb = 1'b0, uv = 1'b0, wrr = 1'b0;
  logic [6:0] ua = 7'h0;
  logic [7:0] ca = 8'h0, cd = 8'h0, ud = 8'h0;
  logic rdy, rv, rn, wv, slp;
  logic [7:0] rdat, wa, wd;
  gi2c_pkg::gi2c_pwr_t pwr = gi2c_pkg::PWR_NORMAL;
  int bad_count = 0;
  int n_compared = 0;
  gi2c_if bus_if ();
  // Clock
  always #50 clk_i = ~clk_i;
  gi2c_target #(.TIMEOUT_CYCLES(500), .WAKE_CYCLES(50)) gi2c_target_inst (
    .clk_i, .rst_i, .en_i(1'b1), .pwr_state_i(pwr), .flash_busy_i(fb), .upd_valid_i(uv),
    .upd_addr_i(ua), .upd_data_i(ud), .wr_valid_o(wv), .wr_addr_o(wa), .wr_data_o(wd),
    .wr_ready_i(wrr), .bus_sleep_o(slp), .bus(bus_if));
  gi2c_controller #(.POST_WR_CYCLES(1000)) gi2c_controller_inst (
    .clk_i, .rst_i, .en_i(c_en), .cmd_valid_i(vld), .cmd_read_i(rd), .cmd_quick_i(qk),
    .cmd_addr_i(ca), .cmd_data_i(cd), .cmd_ready_o(rdy), .rsp_valid_o(rv),
    .rsp_data_o(rdat), .rsp_nack_o(rn), .bus(bus_if));
  gi2c_link_sva #(.TMO(500)) gi2c_link_sva_inst (
    .clk_i, .rst_i, .scl(bus_if.scl), .sda(bus_if.sda), .dev_scl_oe(bus_if.dev_scl_oe),
    .dev_sda_oe(bus_if.dev_sda_oe));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Request holds until the edge that takes it
  task automatic go(input logic r, input logic q, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {vld, rd, qk, ca, cd} = {1'b1, r, q, a, d};
    for (int i = 0; i < 9000 && rdy !== 1'b1; i++) @(negedge clk_i);
    chk("ready", 8'h1, {7'h0, rdy});
    @(negedge clk_i);
    vld = 1'b0;
  endtask : go
  task automatic op(input logic r, input logic q, input logic [7:0] a, input logic [7:0] d);
    go(r, q, a, d);
    for (int i = 0; i < 9000 && rv !== 1'b1; i++) @(negedge clk_i);
    chk("response", 8'h1, {7'h0, rv});
    chk("gap busy", 8'h0, {7'h0, rdy});
  endtask : op
  task automatic upd(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {uv, ua, ud} = {1'b1, a, d};
    @(negedge clk_i);
    uv = 1'b0;
  endtask : upd
  task automatic see_stretch();
    for (int i = 0; i < 9000 && bus_if.dev_scl_oe !== 1'b1; i++) @(negedge clk_i);
    chk("stretch", 8'h1, {7'h0, bus_if.dev_scl_oe});
  endtask : see_stretch
  // Four writes fill the buffer; the fifth waits on a stretch
  task automatic t_fill();
    for (int k = 0; k < 4; k++) begin
      op(1'b0, 1'b0, 8'(k % 2), 8'ha0 + 8'(k));
      chk("write nack", 8'h0, {7'h0, rn});
    end
    fork
      op(1'b0, 1'b0, 8'h00, 8'ha4);
      begin
        see_stretch();
        for (int k = 0; k < 5; k++) begin
          for (int i = 0; i < 900 && wv !== 1'b1; i++) @(negedge clk_i);
          chk("fifo addr", 8'(k % 2), wa);
          chk("fifo data", 8'ha0 + 8'(k), wd);
          wrr = 1'b1;
          @(negedge clk_i);
          wrr = 1'b0;
        end
        chk("fifo empty", 8'h0, {7'h0, wv});
      end
    join
    @(negedge clk_i);
    wrr = 1'b1;
  endtask : t_fill
  // Refusals around read-only and top locations
  task automatic t_refuse();
    upd(7'h6b, 8'h77);
    op(1'b0, 1'b0, 8'h02, 8'h11);
    chk("ro write nack", 8'h1, {7'h0, rn});
    op(1'b1, 1'b0, 8'h6c, 8'h00);
    chk("high read nack", 8'h1, {7'h0, rn});
    op(1'b1, 1'b0, 8'h6b, 8'h00);
    chk("top read nack", 8'h0, {7'h0, rn});
    chk("top read data", 8'h77, rdat);
  endtask : t_refuse
  // Acked write moves the pointer on by one
  task automatic t_ptr();
    upd(7'h01, 8'h3c);
    op(1'b0, 1'b0, 8'h00, 8'h5e);
    repeat (700) @(negedge clk_i);
    chk("post write wait", 8'h0, {7'h0, rdy});
    op(1'b1, 1'b1, 8'h00, 8'h00);
    chk("quick read", 8'h3c, rdat);
  endtask : t_ptr
  // Awake states need flash busy to stretch; sleepy ones stretch to wake
  task automatic t_stretch(input int p);
    pwr = gi2c_pkg::gi2c_pwr_t'(p);
    fb = (p < 3);
    fork
      op(1'b1, 1'b1, 8'h00, 8'h00);
      begin
        see_stretch();
        repeat (20) @(negedge clk_i);
        fb = 1'b0;
      end
    join
    chk("stretch read", 8'h3c, rdat);
  endtask : t_stretch
  // Controller frozen with the clock low
  task automatic t_tmo();
    pwr = gi2c_pkg::PWR_NORMAL;
    go(1'b1, 1'b1, 8'h00, 8'h00);
    for (int i = 0; i < 900 && bus_if.dev_sda_oe !== 1'b1; i++) @(negedge clk_i);
    chk("address ack", 8'h1, {7'h0, bus_if.dev_sda_oe});
    c_en = 1'b0;
    repeat (600) @(negedge clk_i);
    chk("released", 8'h0, {6'h0, bus_if.dev_scl_oe, bus_if.dev_sda_oe});
    chk("bus sleep", 8'h1, {7'h0, slp});
    rst_i = 1'b1;
    c_en = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk("sleep clear", 8'h0, {7'h0, slp});
  endtask : t_tmo
  // Hang guard, well past the expected run
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
  // Reset, then scenarios in turn
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    t_fill();
    t_refuse();
    t_ptr();
    for (int p = 0; p < 5; p++) t_stretch(p);
    t_tmo();
    close_out();
  end
endmodule : gauge_i2c_target_port_tb_top

/* sim/gi2c_link_sva.sv */
`timescale 1ns/10ps
module gi2c_link_sva #(
  parameter int TMO = 500
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wire levels and device drive
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe
);
  logic        scl_q, sda_q, hit, rd;
  logic [3:0]  bitn;
  logic [1:0]  byten;
  logic [7:0]  sh, ptr;
  logic [15:0] lowc;
  // Framing rebuilt from the wire; byte index saturates to save bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_q, sda_q} <= 2'h3;
      {hit, rd, bitn, byten, sh, ptr, lowc} <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      lowc  <= (scl && sda) ? 16'h0 : lowc + 16'h1;
      if (scl && scl_q && sda_q && !sda) begin
        bitn  <= 4'h0;
        byten <= 2'h0;
      end else if (scl && !scl_q && bitn == 4'h8) begin
        bitn  <= 4'h0;
        byten <= (byten == 2'h3) ? byten : byten + 2'h1;
        ptr   <= (byten == 2'h1) ? sh : ptr + 8'h1;
        if (byten == 2'h0) begin
          hit <= (sh[7:1] == gi2c_pkg::TARGET_ADDR);
          rd  <= sh[0];
        end
      end else if (scl && !scl_q) begin
        sh   <= {sh[6:0], sda};
        bitn <= bitn + 4'h1;
      end
    end
  end
  // Ninth clock rising, where the acknowledge is sampled
  sequence ack_rise_s;
    scl && !scl_q && bitn == 4'h8;
  endsequence
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  addr_ack_a: assert property (ack_rise_s ##0 byten == 2'h0 |->
    sda == (sh[7:1] != gi2c_pkg::TARGET_ADDR)) else $error("address ack wrong");
  cmd_nack_a: assert property (ack_rise_s ##0 (byten == 2'h1 && hit && !rd) |->
    sda == (sh > gi2c_pkg::CMD_TOP)) else $error("command ack wrong");
  data_nack_a: assert property (ack_rise_s ##0 (byten > 2'h1 && hit && !rd) |->
    sda == (ptr > gi2c_pkg::CTRL_LAST)) else $error("data ack wrong");
  read_ack_a: assert property (ack_rise_s ##0 (byten != 2'h0 && hit && rd) |->
    !dev_sda_oe) else $error("device held master ack");
  quiet_bus_a: assert property (byten != 2'h0 && !hit |-> !dev_sda_oe)
    else $error("data driven when not addressed");
  stretch_own_a: assert property (dev_scl_oe && byten != 2'h0 |-> hit)
    else $error("stretch in foreign packet");
  data_stable_a: assert property (scl && scl_q && lowc < TMO - 8 |-> $stable(dev_sda_oe))
    else $error("data moved while clock high");
  timeout_free_a: assert property (lowc > TMO + 8 |-> !dev_scl_oe && !dev_sda_oe)
    else $error("lines kept after timeout");
endmodule : gi2c_link_sva
